// ===== logic/hdcw_pkg.sv
// Package with constants and carrier types for the half-duplex control word serial master.
package hdcw_pkg;

  // System clock period and the serial clock period, both in nanoseconds.
  localparam int unsigned SYS_CLK_PERIOD_NS = 20;
  localparam int unsigned SCLK_PERIOD_NS    = 160;

  // Half a serial clock period counted in system clock cycles, never below one.
  localparam int unsigned HALF_CYCLES_RAW = SCLK_PERIOD_NS / (2 * SYS_CLK_PERIOD_NS);
  localparam int unsigned HALF_CYCLES     = (HALF_CYCLES_RAW < 1) ? 1 : HALF_CYCLES_RAW;

  // Frame geometry.
  localparam int unsigned CTRL_BITS     = 8;
  localparam int unsigned RESP_MIN_BITS = 4;
  localparam int unsigned RESP_MAX_BITS = 16;
  localparam logic [3:0]  CTRL_LAST     = 4'h7;
  localparam logic [3:0]  SIZE_MIN_CODE = 4'h3;

  // Values of the link outputs after reset and while idle.
  localparam logic RST_SCLK = 1'b0;
  localparam logic RST_FSS  = 1'b1;
  localparam logic RST_DOUT = 1'b0;

  // Frame sequencer states.
  typedef enum logic [2:0] {
    HDCW_IDLE = 3'b000,
    HDCW_CTRL = 3'b001,
    HDCW_WAIT = 3'b010,
    HDCW_RESP = 3'b011,
    HDCW_TAIL = 3'b100
  } hdcw_state_t;

  // Pins driven towards the slave.
  typedef struct packed {
    logic sclk;
    logic fss;
    logic dout;
    logic doutOe;
  } hdcw_link_out_t;

  // Received word handed to the receive FIFO.
  typedef struct packed {
    logic        valid;
    logic [15:0] data;
  } hdcw_rx_word_t;

endpackage : hdcw_pkg

// ===== logic/hdcw_half_divider.sv
// Divider that gives a one-cycle enable pulse every half serial clock period.
`timescale 1ns/1ps
module hdcw_half_divider
  import hdcw_pkg::*;
#(
  parameter int unsigned HALF = HALF_CYCLES
) (
  input  wire logic sys_clk,
  input  wire logic rst_n,
  input  wire logic run,
  output logic      halfTick
);

  localparam int unsigned CW = (HALF > 1) ? $clog2(HALF) : 1;
  localparam logic [CW-1:0] LAST = CW'(HALF - 1);

  logic [CW-1:0] count_reg;

  // Counter restarts whenever the frame logic is idle so that every frame opens with a full half period.
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      count_reg <= '0;
      halfTick  <= 1'b0;
    end else if (!run) begin
      count_reg <= '0;
      halfTick  <= 1'b0;
    end else if (count_reg == LAST) begin
      count_reg <= '0;
      halfTick  <= 1'b1;
    end else begin
      count_reg <= count_reg + CW'(1);
      halfTick  <= 1'b0;
    end
  end

endmodule : hdcw_half_divider

// ===== logic/hdcw_master.sv
// Half-duplex control word serial master: control byte out, wait state, response word in.
//
// Overview of operation
// R1: Every frame opens with exactly eight control bits.
// R2: Serial input ignored while control word shifts.
// R3: Slave answers one clock after last control bit.
// R4: Response is 4 to 16 bits long.
// R5: Idle: clock low, select high, data low.
// R6: Writing a control byte launches a frame.
// R7: Select falls, oldest byte loaded, MSB driven.
// R8: Select stays low during control phase.
// R9: Slave captures control bits on rising clock.
// R10: Slave drives response bits on falling clock.
// R11: Port samples response bits on rising clock.
// R12: Single: select rises one period later, word stored.
// R13: Slave may release input early or at select.
// R14: Continuous: select held low, frames back to back.
// R15: Next control MSB follows last response bit directly.
// R16: Continuous: word stored on following falling edge.
// R17: Master role fixed by configuration, never switched.
// R18: Transmission disabled: data output not driven.
// R19: Words MSB first, width 4 to 16 bits.
// R20: Serial clock toggles only while transferring.
// R21: Response clocks follow the programmed data size.
`timescale 1ns/1ps
module hdcw_master
  import hdcw_pkg::*;
#(
  parameter int unsigned HALF    = HALF_CYCLES,
  parameter int unsigned RESP_W  = RESP_MAX_BITS,
  parameter bit          IS_MASTER = 1'b1
) (
  input  wire logic                 sys_clk,
  input  wire logic                 rst_n,
  input  wire logic                 txEnable,
  input  wire logic                 contMode,
  input  wire logic [3:0]           dataSize,
  input  wire logic                 txValid,
  input  wire logic [7:0]           txData,
  output logic                      txPop,
  output hdcw_rx_word_t             rxWord,
  output logic                      busy,
  output logic                      serial_clock_pin,
  output logic                      frame_select_pin,
  output logic                      serial_out_pin,
  output logic                      serial_out_pin_oe,
  input  wire logic                 serial_in_pin
);

  // Last response bit index for a size code; codes below the shortest word are raised to it.
  // The code is the bit count minus one, so the same value serves as the last bit index.
  function automatic logic [3:0] respLast(input logic [3:0] code);
    respLast = (code < SIZE_MIN_CODE) ? SIZE_MIN_CODE : code;
  endfunction : respLast

  hdcw_state_t        state_reg;
  // Each link pin has a flip-flop of its own, written by one process only; the carrier gathers them.
  hdcw_link_out_t     linkOut;
  logic               sclk_reg;
  logic               fss_reg;
  logic               dout_reg;
  logic               doutOe_reg;
  logic [7:0]         ctrlShift_reg;
  logic [RESP_W-1:0]  rxShift_reg;
  logic [3:0]         bitCnt_reg;
  logic [3:0]         sizeLast_reg;
  logic               lastSeen_reg;
  logic               inMeta_reg;
  logic               inSync_reg;
  logic               halfTick;
  logic               running;
  logic               startFrame;
  logic               rise;
  logic               fall;
  logic               chainNext;

  // The role is a build-time choice; only the master end exists here, so a slave build launches nothing.
  localparam bit ROLE_MASTER = IS_MASTER; // R17

  assign running    = (state_reg != HDCW_IDLE);
  assign startFrame = ROLE_MASTER && (state_reg == HDCW_IDLE) && txEnable && txValid && !txPop; // R6
  assign rise       = halfTick && !sclk_reg;
  assign fall       = halfTick && sclk_reg;
  assign chainNext  = contMode && txEnable && txValid; // R14

  // Half-period ticks restart at every launch from idle, so the first serial clock rise comes one cycle after
  // a full half period: the tick itself is registered before the clock flip-flop acts on it.
  hdcw_half_divider #(
    .HALF (HALF)
  ) u_div (
    .sys_clk  (sys_clk),
    .rst_n    (rst_n),
    .run      (running),
    .halfTick (halfTick)
  );

  // Serial input comes from the slave's timing, so it passes two flip-flops before anything reads it.
  // Only the second flop is read by the frame logic; the first may still be settling.
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      inMeta_reg <= 1'b0;
      inSync_reg <= 1'b0;
    end else begin
      inMeta_reg <= serial_in_pin;
      inSync_reg <= inMeta_reg;
    end
  end

  // Frame sequencer: control bits, one wait period, response bits, then tail or chained frame.
  // Every serial clock edge comes from one half-period tick, so a frame of N response bits takes
  // 19 + 2N ticks from the select fall to the select rise:
  //   16 ticks for the eight control bits, one rise and one fall each,
  //   2 ticks for the wait period in which the slave decodes the control word,
  //   2N ticks for the response bits, each sampled at its rise,
  //   1 tick of tail with the clock low, which completes one full period after the last capture.
  // The bit counter advances on falling edges only, so a rise always sees the index of the bit
  // that is being sampled, and the size check needs no look-ahead.
  // The response size is latched at launch; changing the size input mid-frame has no effect
  // until the next launch, which keeps the clock count and the received width consistent.
  // A slave build, with the role parameter cleared, never leaves idle, so every pin keeps its idle level.
  // The sequencer has five states in a three-bit code; the unused codes fall back to idle.
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      state_reg    <= HDCW_IDLE;
      bitCnt_reg   <= 4'h0;
      sizeLast_reg <= SIZE_MIN_CODE;
      lastSeen_reg <= 1'b0;
    end else begin
      unique case (state_reg)
        HDCW_IDLE: begin
          lastSeen_reg <= 1'b0;
          if (startFrame) begin
            state_reg    <= HDCW_CTRL; // R1
            bitCnt_reg   <= 4'h0;
            sizeLast_reg <= respLast(dataSize); // R21
          end
        end
        HDCW_CTRL: begin
          if (fall) begin
            if (bitCnt_reg == CTRL_LAST) begin
              state_reg  <= HDCW_WAIT; // R1
              bitCnt_reg <= 4'h0;
            end else begin
              bitCnt_reg <= bitCnt_reg + 4'h1;
            end
          end
        end
        HDCW_WAIT: begin
          // The slave decodes the control word during this whole serial clock period.
          if (fall) begin
            state_reg <= HDCW_RESP; // R3
          end
        end
        HDCW_RESP: begin
          if (rise && bitCnt_reg == sizeLast_reg) begin
            lastSeen_reg <= 1'b1; // R4
          end
          if (fall) begin
            if (lastSeen_reg) begin
              lastSeen_reg <= 1'b0;
              bitCnt_reg   <= 4'h0;
              if (chainNext) begin
                state_reg    <= HDCW_CTRL; // R15
                sizeLast_reg <= respLast(dataSize);
              end else begin
                state_reg <= HDCW_TAIL; // R12
              end
            end else begin
              bitCnt_reg <= bitCnt_reg + 4'h1; // R21
            end
          end
        end
        HDCW_TAIL: begin
          // Half a period after the last falling edge completes one full period since the last capture.
          if (halfTick) begin
            state_reg <= HDCW_IDLE; // R12
          end
        end
        default: begin
          state_reg <= HDCW_IDLE;
        end
      endcase
    end
  end

  // Serial clock toggles only inside the bit phases and rests low otherwise.
  // Outside the bit phases the clock is forced low, so a cut frame can never leave it high.
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      sclk_reg <= RST_SCLK;
    end else if (state_reg == HDCW_CTRL || state_reg == HDCW_WAIT || state_reg == HDCW_RESP) begin
      if (halfTick) begin
        sclk_reg <= !sclk_reg; // R20
      end
    end else begin
      sclk_reg <= RST_SCLK; // R5
    end
  end

  // Frame select falls with the launch and stays low until the tail of the last chained frame.
  // Chained frames never pass through the tail, so select stays low across them without a pulse.
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      fss_reg <= RST_FSS;
    end else if (startFrame) begin
      fss_reg <= 1'b0; // R7
    end else if (state_reg == HDCW_TAIL && halfTick) begin
      fss_reg <= 1'b1; // R12
    end else if (state_reg == HDCW_IDLE) begin
      fss_reg <= RST_FSS; // R5
    end
  end

  // Control byte shifter: loaded at the select fall and again when frames chain, MSB first.
  // Bit 7 leaves at the load itself, so only seven shifts follow and the eighth fall parks the line low.
  // A chained load happens on the same falling edge that ends the response, so no idle gap appears.
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      ctrlShift_reg <= 8'h00;
      dout_reg      <= RST_DOUT;
      txPop         <= 1'b0;
    end else begin
      txPop <= 1'b0;
      if (startFrame) begin
        ctrlShift_reg <= {txData[6:0], 1'b0};
        dout_reg      <= txData[7]; // R7
        txPop         <= 1'b1;
      end else if (state_reg == HDCW_RESP && fall && lastSeen_reg && chainNext) begin
        ctrlShift_reg <= {txData[6:0], 1'b0};
        dout_reg      <= txData[7]; // R15
        txPop         <= 1'b1;
      end else if (state_reg == HDCW_CTRL && fall) begin
        if (bitCnt_reg == CTRL_LAST) begin
          dout_reg <= RST_DOUT;
        end else begin
          dout_reg      <= ctrlShift_reg[7]; // R19
          ctrlShift_reg <= {ctrlShift_reg[6:0], 1'b0};
        end
      end else if (state_reg == HDCW_IDLE) begin
        dout_reg <= RST_DOUT; // R5
      end
    end
  end

  // Data output is released whenever transmission is disabled; pull resistors set the level then.
  // The enable is registered like every pin, so it follows the enable input one cycle later.
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      doutOe_reg <= 1'b0;
    end else begin
      doutOe_reg <= txEnable && ROLE_MASTER; // R18
    end
  end

  // Response shifter samples only in the response phase, so input noise during control bits is discarded.
  // Clearing at the chained frame end lets the next word start from zero without an idle cycle.
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      rxShift_reg <= '0;
    end else if (startFrame) begin
      rxShift_reg <= '0;
    end else if (state_reg == HDCW_RESP && rise && !lastSeen_reg) begin
      rxShift_reg <= {rxShift_reg[RESP_W-2:0], inSync_reg}; // R11
    end else if (state_reg == HDCW_RESP && fall && lastSeen_reg) begin
      rxShift_reg <= '0;
    end
  end
  // While in the control and wait phases the shifter above is frozen. // R2

  // Received word goes out at the chaining falling edge or at the select rise of a single transfer.
  // Data are right aligned: the last bit received is bit 0 and unused upper bits read as zero.
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      rxWord <= '0;
    end else begin
      rxWord.valid <= 1'b0;
      if (state_reg == HDCW_RESP && fall && lastSeen_reg && chainNext) begin
        rxWord.valid <= 1'b1; // R16
        rxWord.data  <= 16'(rxShift_reg);
      end else if (state_reg == HDCW_RESP && fall && lastSeen_reg) begin
        rxWord.data <= 16'(rxShift_reg);
      end else if (state_reg == HDCW_TAIL && halfTick) begin
        rxWord.valid <= 1'b1; // R12
      end
    end
  end

  // Busy flag for the user side, registered like every other output.
  // Busy covers the launch edge itself, so the user side never sees a gap between a pop and busy.
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      busy <= 1'b0;
    end else begin
      busy <= running || startFrame;
    end
  end

  // The four link flip-flops travel together as one carrier towards the pins.
  assign linkOut = '{sclk: sclk_reg, fss: fss_reg, dout: dout_reg, doutOe: doutOe_reg};

  // Pins come straight from the link flip-flops; the carrier adds no logic.
  assign serial_clock_pin  = linkOut.sclk;
  assign frame_select_pin  = linkOut.fss; // R8
  assign serial_out_pin    = linkOut.dout;
  assign serial_out_pin_oe = linkOut.doutOe;

endmodule : hdcw_master

// ===== verif/hdcw_slave_model.sv
// Behavioural slave on the far end of the link.
`timescale 1ns/1ps
module hdcw_slave_model (
  input  wire logic        sys_clk,
  input  wire logic        sclk,
  input  wire logic        fss,
  input  wire logic        dout,
  input  wire logic [4:0]  nBits,
  input  wire logic [15:0] resp,
  output logic             din,
  output logic [7:0]       ctrl
);
  logic sclkQ = 1'b0;
  logic drv   = 1'b0;
  int   rise  = 0;
  int   fall  = 0;

  // Start from known levels so the toggling idle pattern is never unknown.
  initial begin
    din = 1'b0;
    ctrl = 8'h00;
  end

  // Works on the falling system clock, so link edges launched by the master have settled.
  // An undriven line toggles every cycle, so a master sampling at the wrong time sees garbage.
  always @(negedge sys_clk) begin
    sclkQ <= sclk;
    if (!drv) din <= ~din;
    if (fss) begin
      rise = 0;
      fall = 0;
      drv = 0;
    end else if (sclk && !sclkQ) begin
      rise = rise + 1;
      if (rise <= 8) ctrl <= {ctrl[6:0], dout};
    end else if (!sclk && sclkQ) begin
      fall = fall + 1;
      if (fall == 9 + nBits) begin
        drv = 0;
        rise = 0;
        fall = 0;
      end else if (fall >= 9) begin
        drv = 1;
        din <= resp[8 + nBits - fall];
      end
    end
  end
endmodule : hdcw_slave_model

// ===== verif/hdcw_master_checker.sv
// Concurrent checks on the link pins and user strobes of the serial master.
`timescale 1ns/1ps
module hdcw_master_checker
  import hdcw_pkg::*;
#(
  parameter int unsigned HALF      = HALF_CYCLES,
  parameter int unsigned RESP_W    = RESP_MAX_BITS,
  parameter bit          IS_MASTER = 1'b1
) (
  input wire logic       sys_clk,
  input wire logic       rst_n,
  input wire logic       txEnable,
  input wire logic       contMode,
  input wire logic [3:0] dataSize,
  input wire logic       txValid,
  input wire logic [7:0] txData,
  input wire logic       txPop,
  input hdcw_rx_word_t   rxWord,
  input wire logic       busy,
  input wire logic       serial_clock_pin,
  input wire logic       frame_select_pin,
  input wire logic       serial_out_pin,
  input wire logic       serial_out_pin_oe,
  input wire logic       serial_in_pin
);
  logic [15:0] lowCnt;
  logic [7:0]  sameCnt;
  logic [4:0]  nReg;
  logic [3:0]  dsQ;
  logic [3:0]  pops;
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_n);

  // Select-low time, clock level time and launches per select-low span.
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      lowCnt <= '0;
      sameCnt <= '0;
      nReg <= 5'd4;
      dsQ <= '0;
      pops <= '0;
    end else begin
      lowCnt <= frame_select_pin ? 16'h0000 : lowCnt + 16'h0001;
      sameCnt <= $changed(serial_clock_pin) ? 8'h00 : sameCnt + 8'h01;
      dsQ <= dataSize;
      if (txPop) nReg <= (dsQ < SIZE_MIN_CODE) ? 5'd4 : 5'(dsQ) + 5'd1;
      pops <= frame_select_pin ? 4'h0 : pops + 4'(txPop);
    end
  end

  AST_IDLE_LEVELS: assert property (!busy |-> !serial_clock_pin && frame_select_pin && !serial_out_pin)
    else $error("idle link levels wrong");
  AST_SCLK_IN_FRAME: assert property (frame_select_pin |-> !serial_clock_pin)
    else $error("serial clock high outside a frame");
  AST_LAUNCH: assert property (txPop |-> !frame_select_pin && busy && serial_out_pin == $past(txData[7])
    && $past(txValid) && $past(txEnable)) else $error("launch did not follow the offered byte");
  AST_CTRL_PHASE: assert property ($fell(frame_select_pin) |-> (!frame_select_pin && !rxWord.valid)
    throughout (##100 1)) else $error("select left low phase too early");
  AST_SCLK_HIGH: assert property ($fell(serial_clock_pin) |-> sameCnt == HALF - 1)
    else $error("serial clock high time wrong");
  AST_FRAME_LEN: assert property ($rose(frame_select_pin) && pops == 4'h1
    |-> lowCnt == HALF * (19 + 2 * nReg) + 1) else $error("single frame length wrong");
  AST_RX_SINGLE: assert property ($rose(frame_select_pin) |-> rxWord.valid)
    else $error("word not stored at select rise");
  AST_CHAIN: assert property (txPop && !$fell(frame_select_pin) |-> rxWord.valid && $past(contMode))
    else $error("chained frame without store or mode");
  AST_OE_OFF: assert property (!txEnable |=> !serial_out_pin_oe)
    else $error("data output driven while disabled");

  COV_SINGLE: cover property ($rose(frame_select_pin) && rxWord.valid);
  COV_CHAIN: cover property (txPop && !$fell(frame_select_pin));
  COV_HELD: cover property (!txEnable && txValid);
endmodule : hdcw_master_checker

bind hdcw_master hdcw_master_checker #(.HALF(HALF), .RESP_W(RESP_W), .IS_MASTER(IS_MASTER)) chk (
  .sys_clk(sys_clk), .rst_n(rst_n), .txEnable(txEnable), .contMode(contMode), .dataSize(dataSize),
  .txValid(txValid), .txData(txData), .txPop(txPop), .rxWord(rxWord), .busy(busy),
  .serial_clock_pin(serial_clock_pin), .frame_select_pin(frame_select_pin), .serial_out_pin(serial_out_pin),
  .serial_out_pin_oe(serial_out_pin_oe), .serial_in_pin(serial_in_pin));

// ===== verif/testbench.sv
// Self-checking bench for the serial master with a slave model on the link.
`timescale 1ns/1ps
module testbench;
  import hdcw_pkg::*;
  logic          sys_clk  = 1'b0;
  logic          rst_n    = 1'b0;
  logic          txEnable = 1'b1;
  logic          contMode = 1'b0;
  logic [3:0]    dataSize = 4'h3;
  logic          txValid  = 1'b0;
  logic [7:0]    txData   = 8'h00;
  logic          txPop, busy, sclk, fss, dout, doutOe, din;
  hdcw_rx_word_t rxWord;
  logic [15:0]   slvResp  = 16'h0000;
  logic [7:0]    slvCtrl;
  logic [7:0]    eb [64];
  logic [15:0]   er [64];
  logic [3:0]    tbl [4]  = '{4'h0, 4'h2, 4'h3, 4'hf};
  int            pushIdx = 0, popIdx = 0, rxIdx = 0, failures = 0, checks = 0, seed = 24470;

  // Free-running system clock.
  always #10 sys_clk = ~sys_clk;

  hdcw_master DUT (.sys_clk(sys_clk), .rst_n(rst_n), .txEnable(txEnable), .contMode(contMode),
    .dataSize(dataSize), .txValid(txValid), .txData(txData), .txPop(txPop), .rxWord(rxWord), .busy(busy),
    .serial_clock_pin(sclk), .frame_select_pin(fss), .serial_out_pin(dout), .serial_out_pin_oe(doutOe),
    .serial_in_pin(din));
  hdcw_slave_model slave (.sys_clk(sys_clk), .sclk(sclk), .fss(fss), .dout(dout), .nBits(expN(dataSize)),
    .resp(slvResp), .din(din), .ctrl(slvCtrl));

  function automatic logic [4:0] expN(input logic [3:0] ds);
    return (ds < SIZE_MIN_CODE) ? 5'd4 : 5'(ds) + 5'd1;
  endfunction : expN

  function automatic logic [15:0] mask(input logic [3:0] ds);
    return 16'hffff >> (5'd16 - expN(ds));
  endfunction : mask

  task automatic check_bit(input string what, input logic exp, input logic got);
    checks++;
    if (got !== exp) begin
      failures++;
      $display("BAD %s expected %b seen %b", what, exp, got);
    end
  endtask : check_bit

  task automatic check_word(input string what, input logic [15:0] exp, input logic [15:0] got);
    checks++;
    if (got !== exp) begin
      failures++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask : check_word

  task automatic report_and_stop;
    if (failures == 0 && checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : report_and_stop

  // User FIFO in front of the master: pops on the pulse and offers the next byte at once.
  always @(negedge sys_clk) begin
    if (txPop === 1'b1) begin
      slvResp <= er[popIdx];
      popIdx = popIdx + 1;
    end
    txValid = popIdx < pushIdx;
    txData = txValid ? eb[popIdx] : 8'h00;
  end

  // Each stored word must match what the slave sent, and the slave must have heard the byte.
  always @(negedge sys_clk) begin
    if (rxWord.valid === 1'b1) begin
      check_word("rxData", er[rxIdx] & mask(dataSize), rxWord.data);
      check_word("ctrlSeen", {8'h00, eb[rxIdx]}, {8'h00, slvCtrl});
      rxIdx = rxIdx + 1;
    end
  end

  // Queues k random frames at one size; pushing all at once makes the frames back to back when cont is set.
  task automatic run_burst(input logic [3:0] ds, input logic cont, input int k);
    int tgt;
    @(negedge sys_clk);
    dataSize = ds;
    contMode = cont;
    @(posedge sys_clk);
    tgt = pushIdx + k;
    for (int i = 0; i < k; i++) begin
      eb[pushIdx + i] = 8'($random(seed));
      er[pushIdx + i] = 16'($random(seed));
    end
    pushIdx = tgt;
    for (int n = 0; n < 8000 && rxIdx < tgt; n++) @(posedge sys_clk);
    check_bit("burstDone", 1'b1, rxIdx == tgt);
  endtask : run_burst

  // Size codes below the minimum and at both ends first, then random sizes and chained bursts.
  initial begin
    repeat (4) @(posedge sys_clk);
    @(negedge sys_clk);
    rst_n = 1'b1;
    for (int j = 0; j < 10; j++) run_burst(j < 4 ? tbl[j] : 4'($random(seed)), 1'b0, 2);
    run_burst(4'h3, 1'b1, 3);
    run_burst(4'hf, 1'b1, 3);
    @(negedge sys_clk);
    txEnable = 1'b0;
    @(posedge sys_clk);
    eb[pushIdx] <= 8'ha5;
    er[pushIdx] <= 16'h5a5a;
    pushIdx <= pushIdx + 1;
    repeat (40) @(negedge sys_clk);
    check_bit("oeOff", 1'b0, doutOe);
    check_bit("held", 1'b1, popIdx < pushIdx);
    txEnable = 1'b1;
    run_burst(4'hf, 1'b0, 1);
    report_and_stop;
  end

  // Cuts a hang short well beyond the expected run length.
  initial begin
    #600000;
    failures++;
    report_and_stop;
  end
endmodule : testbench
